// ===== inc/attr_sel_pkg.sv
// constants, types and register map for the attribute select block
// assumes a single pclk domain and an APB3 register bus with 32-bit data
`default_nettype none

package attr_sel_pkg;

    localparam int NUM_PINS = 4;

    // register indices; byte address is four times the index
    localparam logic [23:0] ATTR_IDX_0 = 24'hfffff9;
    localparam logic [23:0] ATTR_IDX_1 = 24'hfffff8;
    localparam logic [23:0] ATTR_IDX_2 = 24'hfffff7;
    localparam logic [23:0] ATTR_IDX_3 = 24'hfffff6;
    localparam logic [3:0][31:0] ATTR_ADDR = {
        {6'h00, ATTR_IDX_3, 2'h0}, {6'h00, ATTR_IDX_2, 2'h0},
        {6'h00, ATTR_IDX_1, 2'h0}, {6'h00, ATTR_IDX_0, 2'h0}};
    localparam logic [31:0] STATUS_ADDR = 32'h00000000;

    // attribute register fields
    localparam int MATCH_ADDR_LSB = 12;
    localparam int MATCH_ADDR_W = 12;
    localparam int BIT_COUNT_LSB = 8;
    localparam int BIT_COUNT_W = 4;
    localparam int PACK_BIT = 7;
    localparam int Y_EN_BIT = 5;
    localparam int X_EN_BIT = 4;
    localparam int P_EN_BIT = 3;
    localparam logic [23:0] ATTR_RESET = 24'h000000;
    localparam logic [23:0] ATTR_WMASK = 24'hffffb8;

    // status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_PACKED = 1;
    localparam int ST_BYTE_LSB = 2;
    localparam int ST_PIN_LSB = 4;

    // packed transfer: bytes 0..2
    localparam logic [1:0] FIRST_BYTE = 2'h0;
    localparam logic [1:0] LAST_BYTE = 2'h2;

    typedef enum logic [1:0] {SPACE_X, SPACE_Y, SPACE_P} space_t;

    typedef struct packed {
        logic [23:0] addr;
        space_t space;
        logic dma;
        logic write;
        logic [23:0] wdata;
        logic internal;
    } acc_cmd_t;

endpackage

`default_nettype wire

// ===== hw/attr_match.sv
// address compare for one attribute select pin
// assumes the attribute word and the access fields are stable for the cycle
`default_nettype none

module attr_match import attr_sel_pkg::*; (
    // programmed attribute word
    input wire logic [23:0] attr,
    // access under test
    input wire logic [23:0] addr,
    input wire space_t space,
    input wire logic internal,
    // results
    output logic space_en,
    output logic zero_count,
    output logic hit
);
    wire logic [3:0] count;
    wire logic [11:0] mask;
    wire logic addr_eq;

    assign count = attr[BIT_COUNT_LSB +: BIT_COUNT_W];
    // top count bits of the field, matched against the top address bits [R04]
    // one compare for both address modes [R02] [R03]
    assign mask = ~(12'hfff >> count);
    assign addr_eq = ((addr[23:12] ^ attr[MATCH_ADDR_LSB +: MATCH_ADDR_W]) & mask) == 12'h000;
    assign space_en = (space == SPACE_X && attr[X_EN_BIT])    // [R18]
        || (space == SPACE_Y && attr[Y_EN_BIT])                // [R17]
        || (space == SPACE_P && attr[P_EN_BIT]);               // [R19]
    assign zero_count = count == 4'h0;
    // zero count covers all 16M words, but never internal memory [R05] [R06]
    assign hit = space_en && addr_eq && !(zero_count && internal);  // [R01] [R16]

endmodule // attr_match

`default_nettype wire

// ===== hw/address_attribute_chip_select.sv
// attribute select pins, byte packing sequencer and APB register file
// assumes one pclk domain; external completion comes back on ext_ready
`default_nettype none

// Functional notes
// R01 - pin asserts when address matches programmed bits and the space is enabled
// R02 - match address field is bits 23..12, upper twelve of 24-bit address
// R03 - same upper-bit compare applies in 16-bit compatibility mode
// R04 - bit count in bits 11..8 selects how many top bits are compared
// R05 - zero count asserts pin over whole range of every enabled space
// R06 - zero count never asserts pin for internal memory accesses
// R07 - software never programs bit count 1111, 1110 or 1101
// R08 - packing splits a DMA access into three byte accesses at addr, +1, +2
// R09 - little-endian: low byte at lowest address and moved first
// R10 - packed bytes travel on the eight low external data lines
// R11 - packing off means one 24-bit external access per DMA transfer
// R12 - core accesses are never packed
// R13 - software steps DMA by three in two-dimensional mode
// R14 - software keeps the +1 and +2 bytes inside the same decoded range
// R15 - the three byte accesses hold bus mastership as one access
// R16 - each register enables X, Y and program spaces independently
// R17 - Y enable bit 5 gates Y data matches
// R18 - X enable bit 4 gates X data matches
// R19 - program enable bit 3 gates program matches
// R20 - match evaluated once per access and pin held throughout
module address_attribute_chip_select import attr_sel_pkg::*; (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // access request from core or dma
    input wire logic acc_req,
    input wire acc_cmd_t acc_cmd,
    output logic acc_done,
    output logic [23:0] acc_rdata,
    // external port
    output logic [23:0] ext_addr,
    output logic ext_strobe,
    output logic ext_write,
    input wire logic ext_ready,
    input wire logic [23:0] ext_data_in,
    output logic [23:0] ext_data_out,
    output logic ext_data_oe,
    output logic [NUM_PINS-1:0] attribute_select_pin,
    output logic bus_hold
);
    typedef enum logic [1:0] {IDLE, XFER, RESP} xfer_state_t;

    xfer_state_t state;
    xfer_state_t next_state;
    logic [23:0] attr_reg [NUM_PINS];
    acc_cmd_t cmd_q;
    logic packed_q;
    logic [1:0] byte_idx;

    logic [1:0] next_byte_idx;
    logic [23:0] next_ext_addr;
    logic [23:0] next_ext_data_out;
    logic [23:0] next_rdata;
    logic next_strobe;
    logic next_oe;
    logic next_hold;
    logic next_done;
    logic [NUM_PINS-1:0] next_pin;

    // apb decode
    wire logic setup;
    wire logic wr_take;
    wire logic [NUM_PINS-1:0] sel_attr;
    wire logic sel_status;
    wire logic mapped;
    wire logic [31:0] read_mux;
    wire logic [7:0] status_word;

    // match decode
    wire logic [NUM_PINS-1:0] hit_vec;
    wire logic [NUM_PINS-1:0] space_en_vec;
    wire logic [NUM_PINS-1:0] zero_vec;
    wire logic [NUM_PINS-1:0] pack_vec;
    wire logic accept;
    wire logic pack_now;
    wire logic byte_ack;
    wire logic more_bytes;
    wire logic [23:0] cur_byte_addr;
    wire logic [7:0] next_wbyte;
    wire logic [1:0] step_idx;

    assign setup = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite;
    assign sel_status = paddr == STATUS_ADDR;
    assign mapped = (|sel_attr) || sel_status;
    assign status_word = {attribute_select_pin, byte_idx, packed_q, state != IDLE};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            assign sel_attr[gi] = paddr == ATTR_ADDR[gi];
            assign pack_vec[gi] = attr_reg[gi][PACK_BIT];
            attr_match u_match (
                .attr(attr_reg[gi]),
                .addr(acc_cmd.addr),
                .space(acc_cmd.space),
                .internal(acc_cmd.internal),
                .space_en(space_en_vec[gi]),
                .zero_count(zero_vec[gi]),
                .hit(hit_vec[gi])
            );
        end
    endgenerate

    assign read_mux = sel_attr[0] ? {8'h00, attr_reg[0]}
        : sel_attr[1] ? {8'h00, attr_reg[1]}
        : sel_attr[2] ? {8'h00, attr_reg[2]}
        : sel_attr[3] ? {8'h00, attr_reg[3]}
        : sel_status ? {24'h000000, status_word}
        : 32'h00000000;

    // register file; writes land at the completing access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                attr_reg[i] <= ATTR_RESET;
            end
        end else if (wr_take) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (sel_attr[i]) begin
                    attr_reg[i] <= pwdata[23:0] & ATTR_WMASK;
                end
            end
        end
    end

    // one wait-free access phase: ready is raised in the cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= setup ? read_mux : prdata;
        end
    end

    // transfer sequencer
    assign accept = state == IDLE && acc_req;
    // packing is for dma only, and only when a hitting register asks for it
    assign pack_now = acc_cmd.dma && |(hit_vec & pack_vec);      // [R12]
    assign byte_ack = state == XFER && ext_ready;
    assign more_bytes = packed_q && byte_idx != LAST_BYTE;
    // built from the current index, so the next-state logic never reads itself
    assign step_idx = byte_idx + 2'h1;
    assign cur_byte_addr = cmd_q.addr + {22'h0, step_idx};
    assign next_wbyte = cmd_q.wdata[8 * step_idx +: 8];

    always_comb begin
        next_state = state;
        next_byte_idx = byte_idx;
        next_ext_addr = ext_addr;
        next_ext_data_out = ext_data_out;
        next_rdata = acc_rdata;
        next_strobe = ext_strobe;
        next_oe = ext_data_oe;
        next_hold = bus_hold;
        next_done = 1'b0;
        next_pin = attribute_select_pin;
        unique case (state)
            IDLE: begin
                if (acc_req) begin
                    next_state = XFER;
                    next_byte_idx = FIRST_BYTE;
                    next_ext_addr = acc_cmd.addr;
                    // low byte first on the low lanes when packing [R09] [R10]
                    next_ext_data_out = pack_now ? {16'h0000, acc_cmd.wdata[7:0]}
                        : acc_cmd.wdata;                          // [R11]
                    next_strobe = 1'b1;
                    next_oe = acc_cmd.write;
                    next_hold = pack_now;                         // [R15]
                    next_pin = hit_vec;                           // [R01] [R20]
                end
            end
            XFER: begin
                if (byte_ack) begin
                    if (packed_q) begin
                        next_rdata[8 * byte_idx +: 8] = ext_data_in[7:0];  // [R09] [R10]
                    end else begin
                        next_rdata = ext_data_in;                 // [R11]
                    end
                    if (more_bytes) begin
                        // pins and hold stay put between bytes [R15] [R20]
                        next_byte_idx = step_idx;
                        next_ext_addr = cur_byte_addr;            // [R08]
                        next_ext_data_out = {16'h0000, next_wbyte};  // [R10]
                    end else begin
                        next_state = RESP;
                        next_strobe = 1'b0;
                        next_oe = 1'b0;
                        next_hold = 1'b0;
                        next_done = 1'b1;
                        next_pin = {NUM_PINS{1'b0}};
                    end
                end
            end
            RESP: begin
                // gap cycle so a request still high under done is not retaken
                next_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= IDLE;
            cmd_q <= '0;
            packed_q <= 1'b0;
            byte_idx <= FIRST_BYTE;
            ext_addr <= 24'h000000;
            ext_data_out <= 24'h000000;
            acc_rdata <= 24'h000000;
            ext_strobe <= 1'b0;
            ext_write <= 1'b0;
            ext_data_oe <= 1'b0;
            bus_hold <= 1'b0;
            acc_done <= 1'b0;
            attribute_select_pin <= {NUM_PINS{1'b0}};
        end else begin
            state <= next_state;
            byte_idx <= next_byte_idx;
            ext_addr <= next_ext_addr;
            ext_data_out <= next_ext_data_out;
            acc_rdata <= next_rdata;
            ext_strobe <= next_strobe;
            ext_data_oe <= next_oe;
            bus_hold <= next_hold;
            acc_done <= next_done;
            attribute_select_pin <= next_pin;
            if (accept) begin
                cmd_q <= acc_cmd;
                packed_q <= pack_now;                             // [R08] [R11]
                ext_write <= acc_cmd.write;
            end
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_pack_start;
        accept && pack_now;
    endsequence

    sequence s_first_byte_out;
        ext_strobe && byte_idx == FIRST_BYTE && ext_addr == $past(acc_cmd.addr);
    endsequence

    property p_pack_starts_low;
        s_pack_start |=> s_first_byte_out and bus_hold;
    endproperty

    // high byte travels last on the low lanes
    property s_pack_last_read;
        state == XFER && packed_q && ext_ready && byte_idx == LAST_BYTE
            |=> acc_rdata[23:16] == $past(ext_data_in[7:0]);
    endproperty

    a_pin_from_match: assert property (accept |=> attribute_select_pin == $past(hit_vec)) // [R01]
        else $error("attribute pins differ from the match taken at accept");

    a_pin_steady_xfer: assert property ((state == XFER && $past(state) == XFER) // [R20]
        |-> $stable(attribute_select_pin))
        else $error("attribute pins changed inside one access");

    a_space_gate_pins: assert property (accept // [R16] [R17] [R18] [R19]
        |=> (attribute_select_pin & ~$past(space_en_vec)) == 4'h0)
        else $error("pin asserted for a space that is not enabled");

    a_zero_cnt_range: assert property (accept && !acc_cmd.internal // [R05]
        |=> ((attribute_select_pin ^ $past(space_en_vec)) & $past(zero_vec)) == 4'h0)
        else $error("zero count pin does not follow its space enables");

    a_zero_cnt_internal: assert property (accept && acc_cmd.internal // [R06]
        |=> (attribute_select_pin & $past(zero_vec)) == 4'h0)
        else $error("zero count pin asserted on internal access");

    a_pack_first_byte: assert property (p_pack_starts_low) // [R08]
        else $error("packed transfer did not start at the dma address");

    a_pack_three_bytes: assert property (acc_done && packed_q |-> byte_idx == LAST_BYTE) // [R08]
        else $error("packed transfer ended before three bytes");

    a_byte_order: assert property (state == XFER && packed_q // [R09]
        |-> ext_addr == cmd_q.addr + {22'h0, byte_idx}
        && ext_data_out[7:0] == cmd_q.wdata[8 * byte_idx +: 8])
        else $error("packed byte address or lane order wrong");

    a_low_lanes_only: assert property (ext_data_oe && packed_q // [R10]
        |-> ext_data_out[23:8] == 16'h0000)
        else $error("packed write drives upper data lines");

    a_unpacked_single: assert property (acc_done && !packed_q |-> byte_idx == FIRST_BYTE) // [R11]
        else $error("unpacked transfer took more than one access");

    a_core_not_packed: assert property (state == XFER && !cmd_q.dma |-> !packed_q) // [R12]
        else $error("core access was packed");

    a_hold_through_pack: assert property (state == XFER && packed_q // [R15]
        |-> bus_hold && ext_strobe)
        else $error("bus released inside a packed transfer");

    a_pin_idle_low: assert property (state != XFER // [R01] [R20]
        |-> attribute_select_pin == 4'h0)
        else $error("attribute pins high outside an access");

    a_hold_unpacked_low: assert property (state == XFER && !packed_q |-> !bus_hold) // [R11]
        else $error("bus held during an unpacked transfer");

    sequence s_byte_taken;
        state == XFER && packed_q && ext_ready && byte_idx != LAST_BYTE;
    endsequence

    a_byte_step: assert property (s_byte_taken // [R08] [R20]
        |=> ext_addr == $past(ext_addr) + 24'h000001 && $stable(attribute_select_pin))
        else $error("next packed byte not at the following address");

    a_high_byte_last: assert property (s_pack_last_read) // [R09] [R10]
        else $error("last packed byte did not land in the high slot");

    a_unpacked_word: assert property (state == XFER && !packed_q && ext_ready // [R11]
        |=> acc_rdata == $past(ext_data_in))
        else $error("unpacked read word not taken whole");

    a_release_at_done: assert property (acc_done |-> !bus_hold && !ext_strobe) // [R15]
        else $error("bus still held when the transfer finished");

endmodule // address_attribute_chip_select

`default_nettype wire

// ===== test/ext_memory_model.sv
// external memories and peripherals behind the attribute select pins
// assumes ext_strobe is held through a transfer; answers at once or after three waits
`default_nettype none

module ext_memory_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // external port
    input wire logic [23:0] ext_addr,
    input wire logic ext_strobe,
    input wire logic ext_write,
    input wire logic [23:0] ext_data_out,
    output logic ext_ready,
    output logic [23:0] ext_data_in,
    // answer delay select
    input wire logic slow
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [23:0] mem [0:255];
    logic [23:0] junk;
    logic [1:0] waits;
    logic byte_dev;
    logic [23:0] word;

    // byte-wide part drives only the low lines; the rest float
    assign byte_dev = ext_addr[23:12] == 12'h000;
    assign word = mem[ext_addr[7:0]];
    // undriven lines change every cycle so a stale value never matches
    assign ext_data_in = ext_ready ? {byte_dev ? junk[23:8] : word[23:8], word[7:0]} : junk;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ready <= 1'b0;
            waits <= 2'h0;
            junk <= 24'h5a5a5a;
        end else begin
            junk <= {junk[22:0], junk[23] ^ junk[22] ^ junk[21] ^ junk[16]};
            if (ext_ready || !ext_strobe) begin
                ext_ready <= 1'b0;
                waits <= 2'h0;
            end else if (waits == (slow ? 2'h3 : 2'h0))
                ext_ready <= 1'b1;
            else
                waits <= waits + 2'h1;
            if (ext_strobe && ext_ready && ext_write)
                mem[ext_addr[7:0]] <= ext_data_out;
        end
    end
endmodule // ext_memory_model

`default_nettype wire

// ===== test/testbench.sv
// self-checking bench: apb register access and core/dma transfers
// assumes the external memory model answers every strobe
`default_nettype none

module testbench import attr_sel_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [31:0] paddr, pwdata, prdata;
    logic acc_req, acc_done, ext_strobe, ext_write, ext_ready, ext_data_oe, bus_hold;
    acc_cmd_t acc_cmd;
    logic [23:0] acc_rdata, ext_addr, ext_data_in, ext_data_out;
    logic [3:0] pins;
    logic [23:0] shadow [0:3];
    logic [23:0] qa [$];
    logic [23:0] qd [$];
    logic [3:0] qp [$];
    logic qh [$];
    int fails = 0;
    int checks = 0;

    address_attribute_chip_select DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .acc_req(acc_req), .acc_cmd(acc_cmd),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .ext_addr(ext_addr),
        .ext_strobe(ext_strobe), .ext_write(ext_write), .ext_ready(ext_ready),
        .ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .attribute_select_pin(pins), .bus_hold(bus_hold));
    ext_memory_model mem_model (.pclk(pclk), .presetn(presetn), .ext_addr(ext_addr),
        .ext_strobe(ext_strobe), .ext_write(ext_write), .ext_data_out(ext_data_out),
        .ext_ready(ext_ready), .ext_data_in(ext_data_in), .slow(slow));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(pready, 1'b1);
        if (pready !== 1'b1)
            close_out();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input int i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ATTR_ADDR[i], d, r, e);
        // reserved bits 6, 2..0 never hold a value
        shadow[i] = d[23:0] & 24'hffffb8;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check(e, err);
    endtask

    // pins expected from the shadow copies of the attribute registers
    function automatic logic [3:0] exp_pins(input logic [23:0] a, input space_t s,
                                            input logic in);
        logic [3:0] p;
        int n;
        for (int i = 0; i < 4; i++) begin
            n = shadow[i][11:8];
            p[i] = shadow[i][s == SPACE_X ? 4 : s == SPACE_Y ? 5 : 3]
                && (n == 0 ? !in : ((a ^ shadow[i]) & ~(24'hffffff >> n)) == 24'h0);
        end
        return p;
    endfunction

    // one access; d is write data, or the expected read data
    task automatic go(input logic [23:0] a, input space_t s, input logic dma, input logic w,
                      input logic [23:0] d, input logic in, input int beats);
        int n;
        logic [3:0] p;
        qa.delete();
        qd.delete();
        qp.delete();
        qh.delete();
        p = exp_pins(a, s, in);
        @(posedge pclk);
        acc_cmd <= acc_cmd_t'{a, s, dma, w, d, in};
        acc_req <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (acc_done !== 1'b1 && n < 60);
        acc_req <= 1'b0;
        check(acc_done, 1'b1);
        if (acc_done !== 1'b1)
            close_out();
        check(qa.size(), beats);
        for (int k = 0; k < qa.size(); k++) begin
            check(qa[k], a + k);
            check(qp[k], p);
            check(qh[k], beats == 3);
            if (w)
                check(qd[k], beats == 3 ? {16'h0, d[8*k +: 8]} : d);
        end
        if (!w)
            check(acc_rdata, d);
    endtask

    always @(posedge pclk) begin
        if (ext_strobe === 1'b1 && ext_ready === 1'b1) begin
            qa.push_back(ext_addr);
            qd.push_back(ext_data_out);
            qp.push_back(pins);
            qh.push_back(bus_hold);
            if (ext_write)
                check(ext_data_oe, 1'b1);
            else
                check(ext_data_oe, 1'b0);
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        {presetn, psel, penable, pwrite, acc_req, slow} = 6'h00;
        paddr = 32'h0;
        pwdata = 32'h0;
        acc_cmd = '0;
        for (int i = 0; i < 4; i++)
            shadow[i] = 24'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd_chk(ATTR_ADDR[i], 32'h0, 1'b0);
        rd_chk(32'h00000100, 32'h0, 1'b1);
        wr_reg(0, 32'hffffffff);
        rd_chk(ATTR_ADDR[0], 32'h00ffffb8, 1'b0);
        // only legal bit counts are programmed
        wr_reg(0, 32'h00abc310);
        wr_reg(2, 32'h00123c38);
        wr_reg(3, 32'h004001b8);
        for (int s = 0; s < 3; s++) begin
            wr_reg(1, 32'h8 << s);
            for (int t = 0; t < 3; t++)
                go(24'ha12345, space_t'(t), 1'b0, 1'b1, 24'h00c0de, 1'b0, 1);
        end
        go(24'ha12345, SPACE_Y, 1'b0, 1'b1, 24'h00c0de, 1'b1, 1);
        go(24'h812345, SPACE_X, 1'b0, 1'b1, 24'h00c0de, 1'b0, 1);
        go(24'h123456, SPACE_P, 1'b0, 1'b1, 24'h0b0b0b, 1'b0, 1);
        go(24'h124000, SPACE_P, 1'b0, 1'b1, 24'h0c0c0c, 1'b0, 1);
        slow <= 1'b1;
        // all three bytes stay inside one decoded range
        go(24'h000100, SPACE_X, 1'b1, 1'b1, 24'h332211, 1'b0, 3);
        go(24'h000100, SPACE_X, 1'b1, 1'b0, 24'h332211, 1'b0, 3);
        // dma steps by three, so packed bursts stay sequential
        go(24'h000103, SPACE_X, 1'b1, 1'b1, 24'h665544, 1'b0, 3);
        go(24'h000103, SPACE_X, 1'b1, 1'b0, 24'h665544, 1'b0, 3);
        go(24'h400210, SPACE_X, 1'b0, 1'b1, 24'habcdef, 1'b0, 1);
        go(24'h400210, SPACE_X, 1'b0, 1'b0, 24'habcdef, 1'b0, 1);
        go(24'h900000, SPACE_X, 1'b1, 1'b1, 24'h123456, 1'b0, 1);
        close_out();
    end
endmodule // testbench

`default_nettype wire
